// >>> binding_endpoint_table_manager.v
// Binding and endpoint table manager driven by host table commands
//
// Summary of operation
// R1 - Four received-data binding slots; three latest packets, one kept invalid.
// R2 - Received packet fills the invalid slot, then oldest valid slot invalidated.
// R3 - Binding table: 0 coord,1 aggr,2 explicit,5-6 command,7-10 rx,11-12 user.
// R4 - Explicit transmission overwrites the explicit binding entry.
// R5 - Add-binding creates the host-supplied entry at a user binding index.
// R6 - Remove-binding deletes the entry at a user binding index.
// R7 - View-binding returns one or more requested binding entries.
// R8 - Save-binding copies the whole binding table to non-volatile storage.
// R9 - Transmit source endpoint must be in the endpoint table first.
// R10 - Endpoint table: 0 command, 1 data read-only; 2 explicit, 3-4 user.
// R11 - Data endpoint entry is always present.
// R12 - Command endpoint entry is always present.
// R13 - Absent transmit source endpoint is placed temporarily at index 2.
// R14 - Add-endpoint creates an entry at a user endpoint index.
// R15 - Remove-endpoint deletes the entry at a user endpoint index.
// R16 - View-endpoint returns one or more requested endpoint entries.
// R17 - User endpoints change only on host commands.
// R18 - Endpoint table saved to storage only on the parameter-write command.
// R19 - Add or remove on a read-only index is refused with an error.
`timescale 1ns/1ps
`include "table_map.vh"

module binding_endpoint_table_manager (
    clk_sys,
    reset_n,
    cmd_valid,
    cmd_ready,
    cmd_code,
    cmd_index,
    cmd_count,
    cmd_entry,
    cmd_endpoint,
    rsp_valid,
    rsp_status,
    rsp_last,
    rsp_index,
    rsp_bind_entry,
    rsp_ep_entry,
    rx_valid,
    rx_entry,
    tx_valid,
    tx_explicit,
    tx_entry,
    tx_src_ep,
    tx_src_ok,
    nv_ready,
    nv_write,
    nv_is_ep,
    nv_index,
    nv_data
);
    input wire clk_sys;
    input wire reset_n;
    input wire cmd_valid;
    output wire cmd_ready;
    input wire [`CMD_W-1:0] cmd_code;
    input wire [`BIND_IDX_W-1:0] cmd_index;
    input wire [`BIND_IDX_W-1:0] cmd_count;
    input wire [`BENT_DATA_W-1:0] cmd_entry;
    input wire [7:0] cmd_endpoint;
    output reg rsp_valid;
    output reg [1:0] rsp_status;
    output reg rsp_last;
    output reg [`BIND_IDX_W-1:0] rsp_index;
    output reg [`BENT_W-1:0] rsp_bind_entry;
    output reg [`EENT_W-1:0] rsp_ep_entry;
    input wire rx_valid;
    input wire [`BENT_DATA_W-1:0] rx_entry;
    input wire tx_valid;
    input wire tx_explicit;
    input wire [`BENT_DATA_W-1:0] tx_entry;
    input wire [7:0] tx_src_ep;
    output reg tx_src_ok;
    input wire nv_ready;
    output wire nv_write;
    output reg nv_is_ep;
    output wire [`BIND_IDX_W-1:0] nv_index;
    output reg [`BENT_W-1:0] nv_data;

    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_VIEW = 3'b010;
    localparam [2:0] S_SAVE = 3'b100;

    reg [`BENT_W-1:0] bind_mem [0:`BIND_COUNT-1];
    reg [`EENT_W-1:0] ep_mem [0:`EP_COUNT-1];
    reg [2:0] state_reg;
    reg [`BIND_IDX_W-1:0] view_idx_reg;
    reg [`BIND_IDX_W-1:0] view_end_reg;
    reg view_ep_reg;
    reg save_start_reg;
    reg [`BIND_IDX_W-1:0] save_count_reg;
    wire [1:0] free_slot;
    wire [1:0] oldest_slot;
    wire save_busy;
    wire save_done;
    wire take_cmd;
    wire bind_user;
    wire ep_user;
    wire ep_ok;
    wire src_known;
    wire [`BIND_IDX_W-1:0] nv_next_index;
    integer i;

    ////////////////////////////////////////////////////////////////////////
    // Index classification helpers, used by the add and remove command paths only

    // R3 user binding range
    function is_bind_user;
        input [`BIND_IDX_W-1:0] idx;
        begin
            is_bind_user = (idx >= `BIND_USER_LO) && (idx <= `BIND_USER_HI);
        end
    endfunction

    function is_ep_user;
        input [`BIND_IDX_W-1:0] idx;
        begin
            is_ep_user = (idx >= {1'b0, `EP_USER_LO}) &&
                (idx <= {1'b0, `EP_USER_HI});
        end
    endfunction

    // R10 user endpoint range
    assign bind_user = is_bind_user(cmd_index);
    assign ep_user = is_ep_user(cmd_index);
    assign ep_ok = cmd_index < `EP_COUNT;
    assign take_cmd = cmd_valid && cmd_ready;
    // Commands wait while a view or save is streaming
    assign cmd_ready = (state_reg == S_IDLE);

    // R8 mirror of the walk, so nv_data pairs with nv_index
    assign nv_next_index = save_start_reg ? 4'h0 :
        (nv_write && nv_ready && nv_index != save_count_reg - 4'h1) ?
        nv_index + 4'h1 : nv_index;

    // R9 source endpoint lookup
    assign src_known = ep_mem[0][8] && (ep_mem[0][7:0] == tx_src_ep) ||
        ep_mem[1][8] && (ep_mem[1][7:0] == tx_src_ep) ||
        ep_mem[2][8] && (ep_mem[2][7:0] == tx_src_ep) ||
        ep_mem[3][8] && (ep_mem[3][7:0] == tx_src_ep) ||
        ep_mem[4][8] && (ep_mem[4][7:0] == tx_src_ep);

    ////////////////////////////////////////////////////////////////////////
    // Received-data slot rotation and storage walk submodules

    // R1 slot pointer
    rx_slot_rotator u_rot (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .advance(rx_valid),
        .free_slot(free_slot),
        .oldest_slot(oldest_slot)
    );

    // R8 whole table walk
    nv_saver u_save (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .start(save_start_reg),
        .count(save_count_reg),
        .nv_ready(nv_ready),
        .nv_write(nv_write),
        .nv_index(nv_index),
        .busy(save_busy),
        .done(save_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Table storage; radio events and host edits never collide on one index
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (i = 0; i < `BIND_COUNT; i = i + 1) begin
                bind_mem[i] <= {`BENT_W{1'b0}};
            end
            // R12 command endpoint fixed
            ep_mem[0] <= {1'b1, `EP_CMD_VAL};
            // R11 data endpoint fixed
            ep_mem[1] <= {1'b1, `EP_DATA_VAL};
            for (i = 2; i < `EP_COUNT; i = i + 1) begin
                ep_mem[i] <= {`EENT_W{1'b0}};
            end
        end else begin
            // R2 fill free then retire oldest
            if (rx_valid) begin
                bind_mem[`BIND_RX_LO + free_slot] <= {1'b1, rx_entry};
                bind_mem[`BIND_RX_LO + oldest_slot][`BENT_VALID] <= 1'b0;
            end
            // R4 explicit binding overwrite
            if (tx_valid && tx_explicit) begin
                bind_mem[`BIND_EXPL] <= {1'b1, tx_entry};
            end
            // R13 temporary source endpoint
            if (tx_valid && !src_known) begin
                ep_mem[`EP_EXPL_IDX] <= {1'b1, tx_src_ep};
            end
            // R5 add user binding
            if (take_cmd && cmd_code == `CMD_ADD_BIND && bind_user) begin
                bind_mem[cmd_index] <= {1'b1, cmd_entry};
            end
            // R6 remove user binding
            if (take_cmd && cmd_code == `CMD_REM_BIND && bind_user) begin
                bind_mem[cmd_index] <= {`BENT_W{1'b0}};
            end
            // R14 R17 add user endpoint
            if (take_cmd && cmd_code == `CMD_ADD_EP && ep_user) begin
                ep_mem[cmd_index[2:0]] <= {1'b1, cmd_endpoint};
            end
            // R15 remove user endpoint
            if (take_cmd && cmd_code == `CMD_REM_EP && ep_user) begin
                ep_mem[cmd_index[2:0]] <= {`EENT_W{1'b0}};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command sequencer and answers
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= S_IDLE;
            view_idx_reg <= 4'h0;
            view_end_reg <= 4'h0;
            view_ep_reg <= 1'b0;
            save_start_reg <= 1'b0;
            save_count_reg <= 4'h0;
            nv_is_ep <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_status <= `ST_OK;
            rsp_last <= 1'b0;
            rsp_index <= 4'h0;
            rsp_bind_entry <= {`BENT_W{1'b0}};
            rsp_ep_entry <= {`EENT_W{1'b0}};
        end else begin
            rsp_valid <= 1'b0;
            save_start_reg <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (take_cmd) begin
                        rsp_index <= cmd_index;
                        rsp_last <= 1'b1;
                        rsp_status <= `ST_OK;
                        case (cmd_code)
                            `CMD_ADD_BIND, `CMD_REM_BIND: begin
                                rsp_valid <= 1'b1;
                                // R19 read-only binding refused
                                if (!bind_user) begin
                                    rsp_status <= (cmd_index < `BIND_COUNT) ?
                                        `ST_READ_ONLY : `ST_BAD_INDEX;
                                end
                            end
                            `CMD_ADD_EP, `CMD_REM_EP: begin
                                rsp_valid <= 1'b1;
                                // R19 read-only endpoint refused
                                if (!ep_user) begin
                                    rsp_status <= ep_ok ?
                                        `ST_READ_ONLY : `ST_BAD_INDEX;
                                end
                            end
                            `CMD_VIEW_BIND, `CMD_VIEW_EP: begin
                                // R7 R16 start view stream
                                view_ep_reg <= (cmd_code == `CMD_VIEW_EP);
                                view_idx_reg <= cmd_index;
                                view_end_reg <= cmd_index + cmd_count -
                                    4'h1;
                                state_reg <= S_VIEW;
                            end
                            `CMD_SAVE_BIND, `CMD_SAVE_PARAM: begin
                                // R8 R18 storage copy
                                nv_is_ep <= (cmd_code == `CMD_SAVE_PARAM);
                                save_count_reg <=
                                    (cmd_code == `CMD_SAVE_PARAM) ?
                                    4'h5 : 4'hD;
                                save_start_reg <= 1'b1;
                                state_reg <= S_SAVE;
                            end
                            default: begin
                                rsp_valid <= 1'b1;
                            end
                        endcase
                    end
                end
                S_VIEW: begin
                    // One entry per cycle until the requested range ends
                    rsp_valid <= 1'b1;
                    rsp_index <= view_idx_reg;
                    rsp_bind_entry <= (view_idx_reg < `BIND_COUNT) ?
                        bind_mem[view_idx_reg] : {`BENT_W{1'b0}};
                    rsp_ep_entry <= (view_idx_reg < `EP_COUNT) ?
                        ep_mem[view_idx_reg[2:0]] : {`EENT_W{1'b0}};
                    rsp_status <= (view_ep_reg ?
                        view_idx_reg < `EP_COUNT :
                        view_idx_reg < `BIND_COUNT) ? `ST_OK : `ST_BAD_INDEX;
                    rsp_last <= (view_idx_reg == view_end_reg);
                    view_idx_reg <= view_idx_reg + 4'h1;
                    if (view_idx_reg == view_end_reg) begin
                        state_reg <= S_IDLE;
                    end
                end
                S_SAVE: begin
                    if (save_done) begin
                        rsp_valid <= 1'b1;
                        rsp_status <= `ST_OK;
                        rsp_last <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage data fetched for the index in force after this edge, so the
    // word offered always belongs to the index offered
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            nv_data <= {`BENT_W{1'b0}};
            tx_src_ok <= 1'b0;
        end else begin
            tx_src_ok <= tx_valid && src_known;
            if (nv_is_ep) begin
                nv_data <= {{(`BENT_W-`EENT_W){1'b0}},
                    ep_mem[nv_next_index[2:0]]};
            end else begin
                nv_data <= bind_mem[nv_next_index];
            end
        end
    end
endmodule // binding_endpoint_table_manager

// >>> table_map.vh
// Table indices, field layouts, command codes and status codes
`ifndef TABLE_MAP_VH
`define TABLE_MAP_VH

// Binding table
`define BIND_COUNT 13
`define BIND_IDX_W 4
`define BIND_COORD 4'h0
`define BIND_AGGR 4'h1
`define BIND_EXPL 4'h2
`define BIND_CMD_LO 4'h5
`define BIND_RX_LO 4'h7
`define BIND_RX_HI 4'hA
`define BIND_USER_LO 4'hB
`define BIND_USER_HI 4'hC

// Binding entry: {valid, type[7:0], dst_ep[7:0], src_ep[7:0], addr[63:0]}
`define BENT_W 89
`define BENT_VALID 88
`define BENT_DATA_W 88

// Endpoint table
`define EP_COUNT 5
`define EP_IDX_W 3
`define EP_CMD_IDX 3'h0
`define EP_DATA_IDX 3'h1
`define EP_EXPL_IDX 3'h2
`define EP_USER_LO 3'h3
`define EP_USER_HI 3'h4
`define EP_CMD_VAL 8'hE6
`define EP_DATA_VAL 8'hE8
// Endpoint entry: {valid, endpoint[7:0]}
`define EENT_W 9

// Host command codes
`define CMD_W 3
`define CMD_ADD_BIND 3'h1
`define CMD_REM_BIND 3'h2
`define CMD_VIEW_BIND 3'h3
`define CMD_SAVE_BIND 3'h4
`define CMD_ADD_EP 3'h5
`define CMD_REM_EP 3'h6
`define CMD_VIEW_EP 3'h7
`define CMD_SAVE_PARAM 3'h0

// Answer status codes
`define ST_OK 2'h0
`define ST_READ_ONLY 2'h1
`define ST_BAD_INDEX 2'h2

`endif

// >>> rx_slot_rotator.v
// Rotation pointer for the four received-data binding slots
`timescale 1ns/1ps
`include "table_map.vh"

module rx_slot_rotator (
    clk_sys,
    reset_n,
    advance,
    free_slot,
    oldest_slot
);
    input wire clk_sys;
    input wire reset_n;
    input wire advance;
    output wire [1:0] free_slot;
    output wire [1:0] oldest_slot;

    reg [1:0] free_reg;

    ////////////////////////////////////////////////////////////////////////
    // Free slot moves one step per packet; oldest is always the next one
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            free_reg <= 2'h0;
        end else if (advance) begin
            free_reg <= free_reg + 2'h1;
        end
    end

    assign free_slot = free_reg;
    assign oldest_slot = free_reg + 2'h1; // Wraps modulo four
endmodule // rx_slot_rotator

// >>> nv_saver.v
// Sequencer that streams a table out to non-volatile storage
`timescale 1ns/1ps
`include "table_map.vh"

module nv_saver (
    clk_sys,
    reset_n,
    start,
    count,
    nv_ready,
    nv_write,
    nv_index,
    busy,
    done
);
    input wire clk_sys;
    input wire reset_n;
    input wire start;
    input wire [`BIND_IDX_W-1:0] count;
    input wire nv_ready;
    output wire nv_write;
    output reg [`BIND_IDX_W-1:0] nv_index;
    output reg busy;
    output reg done;

    ////////////////////////////////////////////////////////////////////////
    // Walk indices 0..count-1, one per accepted storage write
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            nv_index <= 4'h0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1;
                nv_index <= 4'h0;
            end else if (busy && nv_ready) begin
                if (nv_index == count - 4'h1) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    nv_index <= nv_index + 4'h1;
                end
            end
        end
    end

    // Storage port stalls the walk via nv_ready
    assign nv_write = busy;
endmodule // nv_saver

// >>> table_manager_checker_asserts.sv
// Concurrent checks on the table manager command, transmit and storage ports
`timescale 1ns/1ps
`include "table_map.vh"
module table_manager_checker (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [`CMD_W-1:0] cmd_code,
    input wire logic [`BIND_IDX_W-1:0] cmd_index,
    input wire logic rsp_valid,
    input wire logic [1:0] rsp_status,
    input wire logic [`BIND_IDX_W-1:0] rsp_index,
    input wire logic tx_valid,
    input wire logic [7:0] tx_src_ep,
    input wire logic tx_src_ok,
    input wire logic nv_ready,
    input wire logic nv_write,
    input wire logic nv_is_ep,
    input wire logic [`BIND_IDX_W-1:0] nv_index,
    input wire logic [`BENT_W-1:0] nv_data
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Accepted command, shared by the checks from edit_answer_a to nv_cause_a
    wire take = cmd_valid && cmd_ready;
    wire bind_edit = cmd_code == `CMD_ADD_BIND || cmd_code == `CMD_REM_BIND;
    wire ep_edit = cmd_code == `CMD_ADD_EP || cmd_code == `CMD_REM_EP;
    wire is_save = cmd_code == `CMD_SAVE_BIND || cmd_code == `CMD_SAVE_PARAM;
    sequence view_take_s;
        take && (cmd_code == `CMD_VIEW_BIND || cmd_code == `CMD_VIEW_EP);
    endsequence
    sequence first_beat_s;
        !rsp_valid ##1 rsp_valid && rsp_index == $past(cmd_index, 2);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    edit_answer_a:
    assert property (take && (bind_edit || ep_edit) |=> rsp_valid)
        else $error("edit command not answered next cycle");
    bind_refuse_a:
    assert property (take && bind_edit && cmd_index <= 4'hA
        |=> rsp_status == `ST_READ_ONLY)
        else $error("read-only binding edit not refused");
    user_bind_ok_a:
    assert property (take && bind_edit && cmd_index inside {4'hB, 4'hC}
        |=> rsp_status == `ST_OK)
        else $error("user binding edit not accepted");
    ep_refuse_a:
    assert property (take && ep_edit && cmd_index <= 4'h2
        |=> rsp_status == `ST_READ_ONLY)
        else $error("read-only endpoint edit not refused");
    view_first_a:
    assert property (view_take_s |=> first_beat_s)
        else $error("first view beat late or wrong index");
    busy_ready_a:
    assert property (view_take_s or (take && is_save) |=> !cmd_ready)
        else $error("ready high during view or save");
    save_target_a:
    assert property (take && is_save |=> ##1
        nv_write && nv_is_ep == $past(cmd_code == `CMD_SAVE_PARAM, 2))
        else $error("save started on wrong table");
    nv_cause_a:
    assert property ($rose(nv_write) |-> $past(take && is_save, 2))
        else $error("storage write without save command");
    nv_cmd_word_a:
    assert property (nv_write && nv_is_ep && nv_index == 4'h0
        |-> nv_data == {80'h0, 1'b1, `EP_CMD_VAL})
        else $error("stored command endpoint word wrong");
    nv_data_word_a:
    assert property (nv_write && nv_is_ep && nv_index == 4'h1
        |-> nv_data == {80'h0, 1'b1, `EP_DATA_VAL})
        else $error("stored data endpoint word wrong");
    nv_step_a:
    assert property (nv_write && nv_ready && nv_index != (nv_is_ep ? 4 : 12)
        |=> nv_write && nv_index == $past(nv_index) + 4'h1)
        else $error("storage index did not advance");
    fixed_ep_a:
    assert property (tx_valid && (tx_src_ep == `EP_CMD_VAL
        || tx_src_ep == `EP_DATA_VAL) |=> tx_src_ok)
        else $error("fixed endpoint reported absent");
endmodule // table_manager_checker

bind binding_endpoint_table_manager table_manager_checker i_checker (
    .clk_sys(clk_sys), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_index(cmd_index),
    .rsp_valid(rsp_valid), .rsp_status(rsp_status), .rsp_index(rsp_index),
    .tx_valid(tx_valid), .tx_src_ep(tx_src_ep), .tx_src_ok(tx_src_ok),
    .nv_ready(nv_ready), .nv_write(nv_write), .nv_is_ep(nv_is_ep),
    .nv_index(nv_index), .nv_data(nv_data));

// >>> nv_store_model.sv
// Non-volatile storage model that counts accepted entries
`timescale 1ns/1ps
module nv_store_model (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic stall,
    input wire logic nv_write,
    output logic nv_ready,
    output int writes
);
    logic phase_reg;
    // Stall mode accepts every other cycle, so saves stretch out
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            phase_reg <= 1'b0;
            writes <= 0;
        end else begin
            phase_reg <= ~phase_reg;
            if (nv_write && nv_ready)
                writes <= writes + 1;
        end
    end
    assign nv_ready = !stall || phase_reg;
endmodule // nv_store_model

// >>> binding_endpoint_table_manager_test.sv
// Self-checking bench for the binding and endpoint table manager
`timescale 1ns/1ps
`include "table_map.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    bad_count++; $display("[ERR] %s expected %h seen %h", n, e, g); end end
module binding_endpoint_table_manager_test;
    logic clk_sys = 0, reset_n = 0, cmd_valid = 0, rx_valid = 0;
    logic tx_valid = 0, tx_explicit = 0, stall = 0, nv_ready, lq;
    logic [`CMD_W-1:0] cmd_code = 0;
    logic [3:0] cmd_index = 0, cmd_count = 1, rsp_index, nv_index;
    logic [`BENT_DATA_W-1:0] cmd_entry = 0, rx_entry = 0, tx_entry = 0;
    logic [7:0] cmd_endpoint = 0, tx_src_ep = 0;
    logic cmd_ready, rsp_valid, rsp_last, tx_src_ok, nv_write, nv_is_ep;
    logic [1:0] rsp_status, st;
    logic [`BENT_W-1:0] rsp_bind_entry, nv_data, bq [16];
    logic [`EENT_W-1:0] rsp_ep_entry, eq [16];
    int bad_count = 0, comparisons = 0, writes, nb;
    binding_endpoint_table_manager i_dut (.clk_sys(clk_sys),
        .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_code(cmd_code), .cmd_index(cmd_index), .cmd_count(cmd_count),
        .cmd_entry(cmd_entry), .cmd_endpoint(cmd_endpoint),
        .rsp_valid(rsp_valid), .rsp_status(rsp_status),
        .rsp_last(rsp_last), .rsp_index(rsp_index),
        .rsp_bind_entry(rsp_bind_entry), .rsp_ep_entry(rsp_ep_entry),
        .rx_valid(rx_valid), .rx_entry(rx_entry), .tx_valid(tx_valid),
        .tx_explicit(tx_explicit), .tx_entry(tx_entry),
        .tx_src_ep(tx_src_ep), .tx_src_ok(tx_src_ok), .nv_ready(nv_ready),
        .nv_write(nv_write), .nv_is_ep(nv_is_ep), .nv_index(nv_index),
        .nv_data(nv_data));
    nv_store_model i_nv (.clk_sys(clk_sys), .reset_n(reset_n),
        .stall(stall), .nv_write(nv_write), .nv_ready(nv_ready),
        .writes(writes));
    // Free-running 125 MHz clock
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (bad_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic hang;
        bad_count++;
        close_out();
    endtask
    // One idle cycle first, so cmd_valid never toggles twice in a step
    task automatic cmd(input logic [2:0] c, input logic [3:0] i, n);
        nb = 0;
        @(negedge clk_sys);
        for (int k = 0; !cmd_ready; k++) begin
            if (k > 50) hang();
            @(negedge clk_sys);
        end
        {cmd_code, cmd_index, cmd_count, cmd_valid} = {c, i, n, 1'b1};
        @(negedge clk_sys);
        cmd_valid = 0;
        for (int k = 0; k < 200; k++) begin
            if (rsp_valid) begin
                st = rsp_status;
                lq = rsp_last;
                bq[nb] = rsp_bind_entry;
                eq[nb] = rsp_ep_entry;
                nb++;
                if (rsp_last || !(c inside {`CMD_VIEW_BIND, `CMD_VIEW_EP}))
                    return;
            end
            @(negedge clk_sys);
        end
        hang();
    endtask
    task automatic tx_send(input logic [7:0] ep, input logic x, e);
        @(negedge clk_sys);
        {tx_src_ep, tx_explicit, tx_valid} = {ep, x, 1'b1};
        tx_entry = 88'hBEEF;
        @(negedge clk_sys);
        tx_valid = 0;
        `CHK("tx_src_ok", e, tx_src_ok)
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic reset_view;
        cmd(`CMD_VIEW_EP, 0, 5);
        `CHK("ep beats", 5, nb)
        `CHK("ep cmd", {1'b1, `EP_CMD_VAL}, eq[0])
        `CHK("ep data", {1'b1, `EP_DATA_VAL}, eq[1])
        for (int k = 2; k < 5; k++) `CHK("ep free", 1'b0, eq[k][8])
        cmd(`CMD_VIEW_BIND, 0, 13);
        `CHK("bind beats", 13, nb)
        for (int k = 0; k < 13; k++) `CHK("bind", 1'b0, bq[k][88])
    endtask
    task automatic refuse_sweep;
        logic [2:0] cs [4] = '{`CMD_ADD_BIND, `CMD_REM_BIND, `CMD_ADD_EP,
            `CMD_REM_EP};
        logic [1:0] e;
        for (int c = 0; c < 4; c++) begin
            for (int i = 0; i < 16; i++) begin
                if (c < 2)
                    e = i > 12 ? `ST_BAD_INDEX : i > 10 ? `ST_OK : 2'h1;
                else
                    e = i > 4 ? `ST_BAD_INDEX : i > 2 ? `ST_OK : 2'h1;
                cmd(cs[c], i[3:0], 1);
                `CHK("status", e, st)
            end
        end
        reset_view();
    endtask
    task automatic bind_edit;
        cmd_entry = 88'hA1B2C3;
        cmd(`CMD_ADD_BIND, 11, 1);
        cmd_entry = 88'h5A5A;
        cmd(`CMD_ADD_BIND, 12, 1);
        cmd(`CMD_VIEW_BIND, 11, 2);
        `CHK("user 11", {1'b1, 88'hA1B2C3}, bq[0])
        `CHK("user 12", {1'b1, 88'h5A5A}, bq[1])
        `CHK("last", 1'b1, lq)
        cmd(`CMD_REM_BIND, 11, 1);
        cmd(`CMD_VIEW_BIND, 11, 2);
        `CHK("removed", 1'b0, bq[0][88])
        `CHK("kept", 1'b1, bq[1][88])
    endtask
    // Packet p lands in slot (p-1) mod 4; only the last three stay valid
    task automatic rx_rotate;
        int d;
        for (int n = 1; n <= 6; n++) begin
            @(negedge clk_sys);
            rx_entry = {80'h0, 8'(n)};
            rx_valid = 1;
            @(negedge clk_sys);
            rx_valid = 0;
            cmd(`CMD_VIEW_BIND, 7, 4);
            for (int s = 0; s < 4; s++) begin
                d = (n + 3 - s) % 4;
                `CHK("rx valid", d < 3 && n > d, bq[s][88])
                if (d < 3 && n > d)
                    `CHK("rx data", {1'b1, 80'h0, 8'(n - d)}, bq[s])
            end
        end
    endtask
    task automatic tx_paths;
        tx_send(`EP_DATA_VAL, 1, 1);
        tx_send(`EP_CMD_VAL, 0, 1);
        tx_send(8'h55, 0, 0);
        tx_send(8'h55, 0, 1);
        cmd(`CMD_VIEW_BIND, 2, 1);
        `CHK("explicit", {1'b1, 88'hBEEF}, bq[0])
        cmd(`CMD_VIEW_EP, 2, 3);
        `CHK("temp ep", {1'b1, 8'h55}, eq[0])
        `CHK("user ep", 1'b0, eq[1][8] | eq[2][8])
        cmd_endpoint = 8'h42;
        cmd(`CMD_ADD_EP, 3, 1);
        tx_send(8'h42, 0, 1);
        cmd(`CMD_REM_EP, 3, 1);
        cmd(`CMD_VIEW_EP, 3, 1);
        `CHK("rem ep", 1'b0, eq[0][8])
    endtask
    task automatic save_paths;
        int w;
        stall = 1;
        w = writes;
        cmd(`CMD_SAVE_BIND, 0, 1);
        `CHK("bind saves", w + 13, writes)
        cmd(`CMD_SAVE_PARAM, 0, 1);
        `CHK("ep saves", w + 18, writes)
        stall = 0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Reset for ten cycles, release off the clock edge, then scenarios
    initial begin
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        reset_n = 1;
        reset_view();
        refuse_sweep();
        bind_edit();
        rx_rotate();
        tx_paths();
        save_paths();
        close_out();
    end
endmodule // binding_endpoint_table_manager_test
